// ### bus_initiator.sv
// Bus initiator end with host memory: answers fetches and takes granted writes.
`include "risc_dma_params.svh"

module bus_initiator import risc_dma_pkg::*; #(
    parameter int MEM_WORDS     = 256,
    parameter int FETCH_LATENCY = `FETCH_LATENCY,
    parameter int GRANT_LATENCY = `GRANT_LATENCY
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         load_en,
    input  wire logic [$clog2(MEM_WORDS)-1:0] load_index,
    input  wire logic [31:0]                  load_data,
    output logic                              write_seen_q,
    output logic [31:0]                       last_addr_q,
    output logic [31:0]                       last_data_q,
    output logic [3:0]                        last_be_q,
    dma_link_if.initiator                     link
);

    localparam int AW = $clog2(MEM_WORDS);

    logic [31:0] mem [MEM_WORDS];
    logic [7:0]  segment_fill_count_q;
    logic [7:0]  segment_fill_count_d;
    logic [7:0]  gcnt_q;
    logic [7:0]  gcnt_d;
    logic        ack_d;
    logic        grant_d;
    logic        take;

    // Fetch answers after a fixed latency; write grant after arbitration delay.
    always_comb begin
        ack_d  = 1'b0;
        segment_fill_count_d = 8'h00;
        if (link.fetch_req && !link.fetch_ack) begin
            ack_d  = (segment_fill_count_q == 8'(FETCH_LATENCY - 1));
            segment_fill_count_d = ack_d ? 8'h00 : segment_fill_count_q + 8'h01;
        end
        grant_d = 1'b0;
        gcnt_d  = 8'h00;
        if (link.wr_valid) begin
            grant_d = link.wr_ready || (gcnt_q == 8'(GRANT_LATENCY - 1));
            gcnt_d  = grant_d ? gcnt_q : gcnt_q + 8'h01;
        end
        take = link.wr_valid && link.wr_ready;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            segment_fill_count_q          <= 8'h00;
            gcnt_q          <= 8'h00;
            link.fetch_ack  <= 1'b0;
            link.fetch_data <= 32'h0000_0000;
            link.wr_ready   <= 1'b0;
            write_seen_q    <= 1'b0;
            last_addr_q     <= 32'h0000_0000;
            last_data_q     <= 32'h0000_0000;
            last_be_q       <= 4'h0;
        end else begin
            segment_fill_count_q         <= segment_fill_count_d;
            gcnt_q         <= gcnt_d;
            link.fetch_ack <= ack_d;
            if (ack_d) begin
                // program words come from host memory
                link.fetch_data <= mem[link.fetch_addr[AW+1:2]];
            end
            link.wr_ready <= grant_d;
            write_seen_q  <= take;
            if (take) begin
                last_addr_q <= link.wr_addr;
                last_data_q <= link.wr_data;
                last_be_q   <= link.wr_be;
            end
        end
    end

    // Host memory: software preloads the program, the engine writes pixels.
    always_ff @(posedge clk) begin
        if (load_en) begin
            mem[load_index] <= load_data;
        end else if (take) begin
            for (int b = 0; b < 4; b++) begin
                if (link.wr_be[b]) begin
                    mem[link.wr_addr[AW+1:2]][8*b +: 8] <= link.wr_data[8*b +: 8];
                end
            end
        end
    end

endmodule // bus_initiator

// ### dma_engine.sv
// Three-segment video FIFO drain side and the instruction-driven DMA sequencer.
// Summary of operation
// - FIFO fill and drain proceed at once.
// - Same segment never written on consecutive cycles.
// - One word per cycle; all segments readable together.
// - Average video rate stays below bus rate.
// - Bus latency must stay under overflow bound.
// - Engine runs program held in host memory.
// - Audio instance refuses planar instructions.
// - Each line may have its own target.
// - Loaded start address drives the first fetch.
// - WRITE, SKIP, SYNC and JUMP are supported.
// - Data handed over; initiator drives after grant.
// - Engine detects and handles FIFO overflow.
// - Word bit 0 maps to bus bit 0.
// - Software gives contiguous target per line.
// - Any line anywhere in 32-bit space.
// - Each word carries a four-bit tag.
// - Segment full at 68 or 34 words.
// - Full segment is read that same cycle.
// - Program is two SYNC-bounded lists plus JUMP.
`include "risc_dma_params.svh"

module dma_engine import risc_dma_pkg::*; #(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        pix_valid,
    input  wire logic [1:0]  pix_seg,
    input  wire logic [31:0] pix_data,
    input  wire logic [3:0]  pix_tag,
    input  wire logic        start_load,
    input  wire logic [31:0] start_addr,
    input  wire logic        run_enable,
    input  wire logic        audio_mode,
    output logic             busy_q,
    output logic             overflow_q,
    output logic             seq_err_q,
    output logic             instr_err_q,
    output logic [2:0]       seg_full_q,
    dma_link_if.engine       link
);

    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    // Depth of a segment; segment A is the large one.
    function automatic logic [6:0] seg_depth(input int i);
        seg_depth = (i == 0) ? 7'(`SEG_A_DEPTH) : 7'(`SEG_BC_DEPTH);
    endfunction

    function automatic logic [6:0] seg_level(input int i);
        seg_level = (i == 0) ? `SEG_A_FULL : `SEG_BC_FULL;
    endfunction

    function automatic logic is_line_end(input logic [3:0] tag);
        is_line_end = (tag == `TAG_END_4) || (tag == `TAG_END_3) ||
                      (tag == `TAG_END_2) || (tag == `TAG_END_1);
    endfunction

    // Byte enables follow the valid-byte count of a line-end word.
    function automatic logic [3:0] tag_be(input logic [3:0] tag);
        case (tag)
            `TAG_END_3: tag_be = `BE_3;
            `TAG_END_2: tag_be = `BE_2;
            `TAG_END_1: tag_be = `BE_1;
            default:    tag_be = `BE_4;
        endcase
    endfunction

    // Segment storage: 36-bit words, data in 31:0 and the tag in 35:32.
    logic [35:0] seg_mem [3][`SEG_A_DEPTH];
    logic [6:0]  cnt_q [3];
    logic [6:0]  cnt_d [3];
    logic [6:0]  wp_q [3];
    logic [6:0]  wp_d [3];
    logic [6:0]  rp_q [3];
    logic [6:0]  rp_d [3];
    logic [2:0]  full_now;
    logic [2:0]  eng_pop;
    logic [2:0]  pop;
    logic [2:0]  wr_hit;
    logic        prev_wr_q;
    logic [1:0]  prev_seg_q;
    logic        seq_bad;
    logic        drop_in;
    logic [35:0] head_a;

    // Engine state.
    engine_state_type state_q;
    engine_state_type state_d;
    logic [31:0] pc_q;
    logic [31:0] pc_d;
    logic [31:0] instr_q;
    logic [31:0] instr_d;
    logic [31:0] tgt_q;
    logic [31:0] tgt_d;
    logic [10:0] left_q;
    logic [10:0] left_d;
    logic        loaded_q;
    logic        loaded_d;
    logic        ierr_d;
    logic [12:0] byte_sum;
    engine_state_type after_instr;

    // Two-entry hand-off buffer toward the initiator.
    write_entry_type buf_q [BUF_DEPTH];
    logic [PW-1:0]   bw_q;
    logic [PW-1:0]   br_q;
    logic [PW:0]     bcnt_q;
    logic [PW:0]     bcnt_d;
    logic            bvalid_q;
    logic            buf_push;
    logic            buf_pop;
    logic            buf_room;
    write_entry_type push_entry;

    assign head_a = seg_mem[0][rp_q[0]];

    // Fill and drain act in the same cycle; each segment keeps its own pointers.
    always_comb begin
        seq_bad = pix_valid && prev_wr_q && (pix_seg == prev_seg_q);
        drop_in = 1'b0;
        for (int i = 0; i < 3; i++) begin
            full_now[i] = (cnt_q[i] >= seg_level(i));
            pop[i] = eng_pop[i] || (full_now[i] && (cnt_q[i] != 7'h00));
            wr_hit[i] = pix_valid && !seq_bad && (pix_seg == 2'(i)) &&
                        ((cnt_q[i] < seg_depth(i)) || pop[i]);
            if (pix_valid && !seq_bad && (pix_seg == 2'(i)) && !wr_hit[i]) begin
                drop_in = 1'b1;
            end
            cnt_d[i] = cnt_q[i] + {6'h00, wr_hit[i]} - {6'h00, pop[i]};
            wp_d[i] = wr_hit[i] ? ((wp_q[i] == seg_depth(i) - 7'h01) ? 7'h00 : wp_q[i] + 7'h01) : wp_q[i];
            rp_d[i] = pop[i] ? ((rp_q[i] == seg_depth(i) - 7'h01) ? 7'h00 : rp_q[i] + 7'h01) : rp_q[i];
        end
        if (pix_valid && pix_seg == 2'h3) begin
            drop_in = 1'b1;
        end
    end

    // Segment pointers, counts and the sticky error flags.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                cnt_q[i] <= 7'h00;
                wp_q[i]  <= 7'h00;
                rp_q[i]  <= 7'h00;
            end
            prev_wr_q  <= 1'b0;
            prev_seg_q <= 2'h0;
            seg_full_q <= 3'h0;
            overflow_q <= 1'b0;
            seq_err_q  <= 1'b0;
        end else begin
            cnt_q      <= cnt_d;
            wp_q       <= wp_d;
            rp_q       <= rp_d;
            prev_wr_q  <= |wr_hit;
            prev_seg_q <= pix_seg;
            seg_full_q <= full_now;
            // A full segment drained without the engine asking means lost data.
            overflow_q <= overflow_q || drop_in || |(pop & ~eng_pop);
            seq_err_q  <= seq_err_q || seq_bad;
        end
    end

    // Storage has no reset; words are only read after being counted in.
    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (wr_hit[i]) begin
                seg_mem[i][wp_q[i]] <= {pix_tag, pix_data};
            end
        end
    end

    // Sequencer: fetch, decode and run one instruction at a time.
    always_comb begin
        state_d    = state_q;
        pc_d       = pc_q;
        instr_d    = instr_q;
        tgt_d      = tgt_q;
        left_d     = left_q;
        loaded_d   = loaded_q;
        ierr_d     = instr_err_q && !start_load; // A refusal in the reload cycle still sets it.
        eng_pop    = 3'h0;
        buf_push   = 1'b0;
        // word lands bit-aligned on the bus
        push_entry = '{addr: tgt_q, data: head_a[31:0], be: tag_be(head_a[35:32])};
        byte_sum   = {1'b0, instr_q[11:0]} + 13'h0003;
        after_instr = run_enable ? ST_FETCH0 : ST_IDLE;
        case (state_q)
            ST_IDLE: begin
                if (run_enable && loaded_q) begin
                    state_d = ST_FETCH0;
                end
            end
            ST_FETCH0: begin
                if (link.fetch_ack) begin
                    instr_d = link.fetch_data;
                    pc_d    = pc_q + `INSTR_STEP;
                    if (link.fetch_data[31:28] == `OP_WRITE || link.fetch_data[31:28] == `OP_WRITE_PLANAR ||
                        link.fetch_data[31:28] == `OP_JUMP) begin
                        state_d = ST_FETCH1;
                    end else begin
                        state_d = ST_EXEC;
                    end
                end
            end
            ST_FETCH1: begin
                if (link.fetch_ack) begin
                    if (instr_q[31:28] == `OP_JUMP) begin
                        pc_d    = link.fetch_data;
                        state_d = after_instr;
                    end else begin
                        tgt_d   = link.fetch_data;
                        pc_d    = pc_q + `INSTR_STEP;
                        state_d = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                left_d = byte_sum[12:2];
                case (instr_q[31:28])
                    `OP_WRITE:        state_d = ST_MOVE;
                    `OP_SKIP:         state_d = ST_DROP;
                    `OP_SYNC:         state_d = ST_SYNC;
                    `OP_WRITE_PLANAR: begin
                        if (audio_mode) begin
                            state_d = ST_HALT;
                            ierr_d  = 1'b1;
                        end else begin
                            state_d = ST_MOVE;
                        end
                    end
                    default: begin
                        state_d = ST_HALT;
                        ierr_d  = 1'b1;
                    end
                endcase
            end
            ST_MOVE: begin
                if (left_q == 11'h000) begin
                    state_d = after_instr;
                end else if (cnt_q[0] != 7'h00 && buf_room) begin
                    eng_pop[0] = 1'b1;
                    buf_push   = 1'b1;
                    tgt_d      = tgt_q + `INSTR_STEP;
                    // A line that ends early closes the instruction so the stream resyncs.
                    left_d     = is_line_end(head_a[35:32]) ? 11'h000 : left_q - 11'h001;
                end
            end
            ST_DROP: begin
                if (left_q == 11'h000) begin
                    state_d = after_instr;
                end else begin
                    for (int i = 0; i < 3; i++) begin
                        eng_pop[i] = (cnt_q[i] != 7'h00);
                    end
                    if (cnt_q[0] != 7'h00) begin
                        left_d = left_q - 11'h001;
                    end
                end
            end
            ST_SYNC: begin
                if (cnt_q[0] != 7'h00) begin
                    eng_pop[0] = 1'b1;
                    if (head_a[35:32] == instr_q[3:0]) begin
                        state_d = after_instr;
                    end
                end
            end
            ST_HALT: begin
                state_d = ST_HALT;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // loaded start address begins the program
        if (start_load) begin
            pc_d     = start_addr;
            loaded_d = 1'b1;
            state_d  = ST_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q         <= ST_IDLE;
            pc_q            <= 32'h0000_0000;
            instr_q         <= 32'h0000_0000;
            tgt_q           <= 32'h0000_0000;
            left_q          <= 11'h000;
            loaded_q        <= 1'b0;
            instr_err_q     <= 1'b0;
            busy_q          <= 1'b0;
            link.fetch_req  <= 1'b0;
            link.fetch_addr <= 32'h0000_0000;
        end else begin
            state_q         <= state_d;
            pc_q            <= pc_d;
            instr_q         <= instr_d;
            tgt_q           <= tgt_d;
            left_q          <= left_d;
            loaded_q        <= loaded_d;
            instr_err_q     <= ierr_d;
            busy_q          <= (state_d != ST_IDLE) && (state_d != ST_HALT);
            link.fetch_req  <= (state_d == ST_FETCH0) || (state_d == ST_FETCH1);
            link.fetch_addr <= pc_d;
        end
    end

    // Hand-off buffer: a stalled grant holds words here instead of losing them.
    always_comb begin
        buf_room = (bcnt_q != (PW + 1)'(BUF_DEPTH));
        buf_pop  = bvalid_q && link.wr_ready;
        bcnt_d   = bcnt_q + {{PW{1'b0}}, buf_push} - {{PW{1'b0}}, buf_pop};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bw_q     <= '0;
            br_q     <= '0;
            bcnt_q   <= '0;
            bvalid_q <= 1'b0;
        end else begin
            bcnt_q   <= bcnt_d;
            bvalid_q <= (bcnt_d != '0);
            if (buf_push) begin
                bw_q <= (bw_q == PW'(BUF_DEPTH - 1)) ? '0 : bw_q + PW'(1);
            end
            if (buf_pop) begin
                br_q <= (br_q == PW'(BUF_DEPTH - 1)) ? '0 : br_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (buf_push) begin
            buf_q[bw_q] <= push_entry;
        end
    end

    assign link.wr_valid = bvalid_q;
    assign link.wr_addr  = buf_q[br_q].addr;
    assign link.wr_data  = buf_q[br_q].data;
    assign link.wr_be    = buf_q[br_q].be;

endmodule // dma_engine

// ### dma_link_if.sv
// Link between the DMA sequencer and the bus initiator: fetches and writes.
interface dma_link_if;
    logic        fetch_req;
    logic [31:0] fetch_addr;
    logic        fetch_ack;
    logic [31:0] fetch_data;
    logic        wr_valid;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_be;
    logic        wr_ready;

    modport engine (
        output fetch_req, fetch_addr, wr_valid, wr_addr, wr_data, wr_be,
        input  fetch_ack, fetch_data, wr_ready
    );

    modport initiator (
        input  fetch_req, fetch_addr, wr_valid, wr_addr, wr_data, wr_be,
        output fetch_ack, fetch_data, wr_ready
    );
endinterface

// ### dma_link_sva.sv
// Timing checks on the fetch and write link between the sequencer and the initiator.
module dma_link_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic        fetch_ack,
    input wire logic [31:0] fetch_data,
    input wire logic        wr_valid,
    input wire logic [31:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [3:0]  wr_be,
    input wire logic        wr_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Marks the answer to the first word of a two-word instruction, so a jump target is not taken for a step.
    logic word1_q;
    logic jump_q;
    logic two_word;
    assign two_word = fetch_ack && !word1_q && (fetch_data[31:28] inside {4'h1, 4'h9, 4'h7});
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word1_q <= 1'b0;
            jump_q  <= 1'b0;
        end else if (fetch_ack || !fetch_req) begin
            word1_q <= two_word;
            jump_q  <= two_word && (fetch_data[31:28] == 4'h7);
        end
    end

    // The answer to a fetch comes after four quiet cycles.
    sequence fetch_wait_s;
        !fetch_ack [*4] ##1 fetch_ack;
    endsequence
    // The grant follows a new write request by three cycles.
    sequence grant_wait_s;
        ##3 wr_ready;
    endsequence

    // Requests hold until answered, so neither end may move them early.
    chk_reset_quiet: assert property ($fell(rst) |-> !fetch_req && !wr_valid)
        else $error("link active right after reset");
    chk_fetch_hold: assert property (fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr))
        else $error("fetch request moved before its answer");
    chk_fetch_wait: assert property ($rose(fetch_req) |-> fetch_wait_s)
        else $error("fetch answer not on time");
    chk_ack_pulse: assert property (fetch_ack |=> !fetch_ack)
        else $error("fetch answer longer than one cycle");
    chk_fetch_step: assert property (two_word ##1 fetch_req |-> fetch_addr == $past(fetch_addr) + 32'h4)
        else $error("second fetch word not at next address");
    chk_jump_load: assert property (fetch_ack && word1_q && jump_q ##1 fetch_req |->
        fetch_addr == $past(fetch_data))
        else $error("jump target not used as next fetch address");
    chk_write_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data, wr_be}))
        else $error("write request changed before grant");
    chk_grant_wait: assert property ($rose(wr_valid) |-> grant_wait_s)
        else $error("grant not three cycles after request");
    chk_grant_cause: assert property (wr_ready |-> $past(wr_valid))
        else $error("grant without a write request");
endmodule // dma_link_sva

// ### risc_dma_params.svh
// Shared constants for the DMA sequencer and the bus initiator end.
`ifndef RISC_DMA_PARAMS_SVH
`define RISC_DMA_PARAMS_SVH

// Segment sizes and full thresholds, in words.
`define SEG_A_DEPTH      70
`define SEG_BC_DEPTH     35
`define SEG_A_FULL       7'h44
`define SEG_BC_FULL      7'h22

// Four-bit tags that travel with every stored word.
`define TAG_PLAIN        4'h0
`define TAG_LINE_START   4'h2
`define TAG_PACKED       4'h6
`define TAG_PLANAR       4'he
`define TAG_EVEN_END     4'h4
`define TAG_ODD_END      4'hc
`define TAG_END_4        4'h1
`define TAG_END_3        4'hd
`define TAG_END_2        4'h9
`define TAG_END_1        4'h5

// Byte enables for the last word of a line.
`define BE_4             4'hf
`define BE_3             4'h7
`define BE_2             4'h3
`define BE_1             4'h1

// Instruction opcodes in bits 31:28 of the first word.
`define OP_WRITE         4'h1
`define OP_WRITE_PLANAR  4'h9
`define OP_SKIP          4'h2
`define OP_JUMP          4'h7
`define OP_SYNC          4'h8

// Byte step between instruction words.
`define INSTR_STEP       32'h0000_0004

// Bus end timing, in clock cycles.
`define FETCH_LATENCY    4
`define GRANT_LATENCY    3

`endif

// ### risc_dma_pkg.sv
// Types shared by the DMA sequencer and the bus initiator end.
package risc_dma_pkg;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_FETCH0 = 8'h02,
        ST_FETCH1 = 8'h04,
        ST_EXEC   = 8'h08,
        ST_MOVE   = 8'h10,
        ST_DROP   = 8'h20,
        ST_SYNC   = 8'h40,
        ST_HALT   = 8'h80
    } engine_state_type;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
    } write_entry_type;

endpackage

// ### testbench.sv
// Bench joining the sequencer and the initiator, with a queue model of segment A.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        pix_valid, start_load, run_enable, audio_mode, load_en;
    logic        busy_q, overflow_q, seq_err_q, instr_err_q, write_seen_q;
    logic [1:0]  pix_seg;
    logic [2:0]  seg_full_q;
    logic [3:0]  pix_tag, last_be_q;
    logic [7:0]  load_index;
    logic [31:0] pix_data, start_addr, load_data, last_addr_q, last_data_q;
    logic [67:0] lw = '0;
    logic [35:0] aq[$];
    logic [67:0] eq[$];
    logic [3:0]  tg[9] = '{4'h6, 4'h2, 4'h0, 4'h0, 4'h1, 4'h0, 4'h2, 4'h9, 4'hc};
    logic [31:0] prog[13] = '{32'h8000_0006, 32'h1000_0010, 32'h8000_0100, 32'h2000_0004, 32'h1000_0010,
        32'h0000_4000, 32'h7000_0000, 32'h0000_0024, 32'h8000_0004, 32'h8000_000c, 32'h8000_000e,
        32'h9000_0004, 32'h0000_8000};
    int          errors = 0;
    int          n_checks = 0;
    int          writes = 0;
    int          seen = 0;

    dma_link_if link ();
    dma_engine dma_engine_inst (.clk(clk), .rst(rst), .pix_valid(pix_valid), .pix_seg(pix_seg),
        .pix_data(pix_data), .pix_tag(pix_tag), .start_load(start_load), .start_addr(start_addr),
        .run_enable(run_enable), .audio_mode(audio_mode), .busy_q(busy_q), .overflow_q(overflow_q),
        .seq_err_q(seq_err_q), .instr_err_q(instr_err_q), .seg_full_q(seg_full_q), .link(link));
    bus_initiator bus_initiator_inst (.clk(clk), .rst(rst), .load_en(load_en), .load_index(load_index),
        .load_data(load_data), .write_seen_q(write_seen_q), .last_addr_q(last_addr_q),
        .last_data_q(last_data_q), .last_be_q(last_be_q), .link(link));
    dma_link_sva dma_link_sva_inst (.clk(clk), .rst(rst), .fetch_req(link.fetch_req),
        .fetch_addr(link.fetch_addr), .fetch_ack(link.fetch_ack), .fetch_data(link.fetch_data),
        .wr_valid(link.wr_valid), .wr_addr(link.wr_addr), .wr_data(link.wr_data), .wr_be(link.wr_be),
        .wr_ready(link.wr_ready));

    // Free-running bus clock, 8 ns period.
    always #4 clk = ~clk;

    task automatic check(input logic [67:0] got, input logic [67:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One word per falling edge; callers repeat a segment back to back only in the seq_err_q test.
    task automatic push(input logic [1:0] s, input logic [3:0] t, input logic [31:0] d);
        @(negedge clk);
        pix_valid = 1'b1;
        pix_seg = s;
        pix_tag = t;
        pix_data = d;
    endtask

    task automatic idle(input int n);
        @(negedge clk);
        pix_valid = 1'b0;
        repeat (n) @(negedge clk);
    endtask

    // Last word of a line enables only its valid bytes.
    function automatic logic [3:0] be_of(input logic [3:0] t);
        case (t)
            4'hd: return 4'h7;
            4'h9: return 4'h3;
            4'h5: return 4'h1;
            default: return 4'hf;
        endcase
    endfunction

    // Walks the program over the segment A queue and lists every bus write it implies.
    task automatic run_model();
        int          pc;
        logic [31:0] w0, a;
        logic [35:0] w;
        pc = 0;
        repeat (6) begin
            w0 = prog[pc/4];
            w = '0;
            a = prog[pc/4+1];
            case (w0[31:28])
                4'h8: begin
                    do w = aq.pop_front(); while (w[35:32] !== w0[3:0]);
                    pc += 4;
                end
                4'h2: begin
                    repeat ((w0[11:0] + 3) / 4) void'(aq.pop_front());
                    pc += 4;
                end
                4'h1: begin
                    repeat ((w0[11:0] + 3) / 4) if (!w[32]) begin
                        w = aq.pop_front();
                        eq.push_back({a, w[31:0], be_of(w[35:32])});
                        a += 32'h4;
                    end
                    pc += 8;
                end
                default: pc = a;
            endcase
        end
    endtask

    // Every granted write on the wire is compared with the model's next write.
    // The initiator's record of a write is checked one cycle after it was taken.
    always @(negedge clk) begin
        if (!rst && write_seen_q === 1'b1) begin
            seen++;
            check({last_addr_q, last_data_q, last_be_q}, lw);
        end
        if (!rst && link.wr_valid && link.wr_ready) begin
            writes++;
            lw = eq.pop_front();
            check({link.wr_addr, link.wr_data, link.wr_be}, lw);
        end
    end

    initial begin
        {pix_valid, start_load, run_enable, audio_mode, load_en} = '0;
        {pix_seg, pix_tag, pix_data, start_addr, load_index, load_data} = '0;
        void'($urandom(2612));
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        foreach (prog[i]) begin
            @(negedge clk);
            load_en = 1'b1;
            load_index = i[7:0];
            load_data = prog[i];
        end
        @(negedge clk) load_en = 1'b0;
        start_load = 1'b1;
        @(negedge clk) start_load = 1'b0;
        repeat (6) @(negedge clk);
        check(link.fetch_req, 0);
        check(busy_q, 0);
        run_enable = 1'b1;
        // Segment A words alternate with B so no segment is hit twice in a row.
        // pixel rate below drain rate
        foreach (tg[i]) begin
            aq.push_back({tg[i], $urandom()});
            push(2'd0, tg[i], aq[i][31:0]);
            push(2'd1, 4'h0, $urandom());
        end
        idle(0);
        run_model();
        check(eq.size(), 6);
        for (int k = 0; k < 600 && eq.size() > 0; k++) @(negedge clk);
        // A write that never arrives is a mismatch and ends the run.
        if (eq.size() > 0) begin
            errors++;
            end_of_test();
        end
        idle(4);
        check(writes, 6);
        check(seen, 6);
        check({seq_err_q, overflow_q, instr_err_q, busy_q}, 4'h1);
        // Segment C fills while the engine only drains A.
        for (int i = 1; i <= 34; i++) begin
            push(2'd2, 4'h0, $urandom());
            push(2'd0, 4'h0, $urandom());
            if (i == 33) check({seg_full_q[2], overflow_q}, 2'b00);
        end
        idle(0);
        check(seg_full_q[2], 1);
        idle(2);
        check(overflow_q, 1);
        push(2'd1, 4'h0, $urandom());
        push(2'd1, 4'h0, $urandom());
        idle(1);
        check(seq_err_q, 1);
        // A planar write is refused when the engine serves audio.
        audio_mode = 1'b1;
        start_addr = 32'h0000_002c;
        start_load = 1'b1;
        @(negedge clk) start_load = 1'b0;
        for (int k = 0; k < 60 && instr_err_q !== 1'b1; k++) @(negedge clk);
        if (instr_err_q !== 1'b1) begin
            errors++;
            end_of_test();
        end
        check({instr_err_q, busy_q}, 2'b10);
        check(writes, 6);
        end_of_test();
    end
endmodule // testbench
